// ---- hw/rsc_pkg.sv ----
// rsc_pkg: register map, field positions, codes and timing for the
// reset state manager.
// assumes a 32-bit apb bus and a slow-clock enable pulse from outside.
package rsc_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] RSC_OFF_COMMAND = 8'h00;
	localparam logic [7:0] RSC_OFF_STATUS = 8'h04;
	localparam logic [7:0] RSC_OFF_MODE = 8'h08;
	// ==========================================================
	// field positions
	localparam int RSC_CMD_CPU = 0;
	localparam int RSC_CMD_PERIPH = 2;
	localparam int RSC_CMD_PIN = 3;
	localparam int RSC_KEY_LSB = 24;
	localparam logic [7:0] RSC_KEY = 8'hA5;
	localparam int RSC_ST_USER = 0;
	localparam int RSC_ST_BROWN = 1;
	localparam int RSC_ST_CAUSE_LSB = 8;
	localparam int RSC_ST_PIN = 16;
	localparam int RSC_ST_BUSY = 17;
	localparam int RSC_MD_UREN = 0;
	localparam int RSC_MD_UIEN = 4;
	localparam int RSC_MD_LEN_LSB = 8;
	localparam int RSC_MD_BIEN = 16;
	localparam logic [31:0] RSC_MODE_RESET = 32'h0000_0000;
	// ==========================================================
	// cause codes
	localparam logic [2:0] RSC_CAUSE_POWER = 3'h0;
	localparam logic [2:0] RSC_CAUSE_WDOG = 3'h2;
	localparam logic [2:0] RSC_CAUSE_SW = 3'h3;
	localparam logic [2:0] RSC_CAUSE_USER = 3'h4;
	localparam logic [2:0] RSC_CAUSE_BROWN = 3'h5;
	// ==========================================================
	// timing, in slow-clock cycles
	localparam logic [1:0] RSC_HOLD_CYCLES = 2'd3;
	localparam logic [1:0] RSC_RESYNC_CYCLES = 2'd2;

	typedef enum logic [2:0] {
		RSC_IDLE, RSC_POWER, RSC_BROWN, RSC_WDOG, RSC_SW, RSC_USER,
		RSC_USER_EXIT
	} rsc_state_e;

	// reset lines toward the core, active low
	typedef struct packed {
		logic cpu_n;
		logic periph_n;
		logic pin_n;
	} rsc_resets_s;
endpackage

// ---- hw/rsc_reset_controller.sv ----
// rsc_reset_controller: software, watchdog and user reset arbitration with
// status and mode registers on apb.
// assumes pclk is the master clock and slow_clock_tick is a one-cycle pulse
// per slow-clock period, synchronous to pclk.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_controller
	import rsc_pkg::*;
#(
	parameter int LEN_BITS = 4
)
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset sources
	input wire logic slow_clock_tick,
	input wire logic power_fail,
	input wire logic brownout_detect,
	input wire logic brownout_reset_enable,
	input wire logic wdog_fault,
	input wire logic wdog_reset_enable,
	input wire logic wdog_cpu_only,
	// external reset pin
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// reset lines and interrupt
	output rsc_pkg::rsc_resets_s resets,
	output logic irq
);
	import rsc_pkg::*;

	// the length field has LEN_BITS bits, one to four, in the mode register
	generate
		if (LEN_BITS < 1 || LEN_BITS > 4)
		begin
			$error("LEN_BITS must be 1 to 4");
		end
	endgenerate

	localparam int PCNT_W = (1 << LEN_BITS) + 2;

	// ==========================================================
	// state
	rsc_state_e state_reg, state_next;
	logic [1:0] hold_reg, hold_next;
	logic [2:0] cause_reg, cause_next;
	logic [2:0] pend_cause_reg, pend_cause_next;
	logic cpu_reg, cpu_next;
	logic per_reg, per_next;
	logic busy_reg, busy_next;
	logic [PCNT_W-1:0] pcnt_reg, pcnt_next;
	logic pin_drive_reg, pin_drive_next;
	logic pin_s_reg, pin_s_next;
	logic pin_slow_reg, pin_slow_next;
	logic uflag_reg, uflag_next;
	logic bflag_reg, bflag_next;
	logic bod_d_reg, bod_d_next;
	logic [31:0] mode_reg, mode_next;
	logic [31:0] prdata_next;
	logic pready_next;
	logic irq_next;
	logic pin_drive_d_reg, pin_drive_d_next;
	rsc_resets_s resets_next;

	logic acc, wr, rd;
	logic cmd_ok, cmd_cpu, cmd_per, cmd_pin;
	logic status_read;
	logic wdog_evt, pin_start;
	logic [LEN_BITS-1:0] len;

	function automatic logic [PCNT_W-1:0] pulse_len(
		input logic [LEN_BITS-1:0] l
	);
		pulse_len = PCNT_W'(1) << ({1'b0, l} + 1'b1);
	endfunction

	assign acc = psel && penable && !pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign len = mode_reg[RSC_MD_LEN_LSB +: LEN_BITS];
	// key check, busy lockout, watchdog blocks commands
	assign cmd_ok = wr && paddr == RSC_OFF_COMMAND && !busy_reg
		&& pwdata[RSC_KEY_LSB +: 8] == RSC_KEY
		&& state_reg != RSC_WDOG;
	assign cmd_cpu = cmd_ok && pwdata[RSC_CMD_CPU];
	assign cmd_per = cmd_ok && pwdata[RSC_CMD_PERIPH];
	assign cmd_pin = cmd_ok && pwdata[RSC_CMD_PIN];
	assign status_read = rd && paddr == RSC_OFF_STATUS;
	assign wdog_evt = wdog_fault && wdog_reset_enable;

	// ==========================================================
	// reset state manager
	always_comb
	begin
		state_next = state_reg;
		hold_next = hold_reg;
		cause_next = cause_reg;
		pend_cause_next = pend_cause_reg;
		cpu_next = cpu_reg;
		per_next = per_reg;
		busy_next = busy_reg;
		pin_start = 1'b0;
		pin_slow_next = slow_clock_tick ? pin_s_reg : pin_slow_reg;
		if (power_fail)
		begin
			state_next = RSC_POWER;
			pend_cause_next = RSC_CAUSE_POWER;
			cpu_next = 1'b1;
			per_next = 1'b1;
			busy_next = 1'b0;
			hold_next = RSC_HOLD_CYCLES;
		end
		else if (brownout_detect && brownout_reset_enable
			&& state_reg != RSC_POWER)
		begin
			if (state_reg != RSC_BROWN)
				pin_start = 1'b1;
			state_next = RSC_BROWN;
			pend_cause_next = RSC_CAUSE_BROWN;
			cpu_next = 1'b1;
			per_next = 1'b1;
			busy_next = 1'b0;
			hold_next = RSC_HOLD_CYCLES;
		end
		else if (wdog_evt && (state_reg == RSC_IDLE
			|| state_reg == RSC_SW))
		begin
			state_next = RSC_WDOG;
			pend_cause_next = RSC_CAUSE_WDOG;
			hold_next = RSC_HOLD_CYCLES;
			busy_next = 1'b0;
			cpu_next = 1'b1;
			per_next = !wdog_cpu_only;
			pin_start = !wdog_cpu_only;
		end
		else if (cmd_ok && (cmd_cpu || cmd_per || cmd_pin)
			&& state_reg == RSC_IDLE)
		begin
			state_next = RSC_SW;
			hold_next = RSC_HOLD_CYCLES;
			busy_next = 1'b1;
			cpu_next = cmd_cpu;
			per_next = cmd_per;
			pin_start = cmd_pin;
			pend_cause_next = cmd_cpu ? RSC_CAUSE_SW : cause_reg;
		end
		// the sampled pin trails the drive by a cycle, so wait one more
		else if (state_reg == RSC_IDLE && !pin_s_reg && !pin_drive_reg
			&& !pin_drive_d_reg
			&& mode_reg[RSC_MD_UREN])
		begin
			state_next = RSC_USER;
			pend_cause_next = RSC_CAUSE_USER;
			cpu_next = 1'b1;
			per_next = 1'b1;
		end
		else if (slow_clock_tick)
		begin
			case (state_reg)
				RSC_POWER, RSC_BROWN, RSC_WDOG, RSC_SW:
				begin
					if (hold_reg > 2'd1)
						hold_next = hold_reg - 2'd1;
					else
					begin
						// release on the slow clock
						state_next = RSC_IDLE;
						busy_next = 1'b0;
						if (cpu_reg)
							cause_next = pend_cause_reg;
						cpu_next = 1'b0;
						per_next = 1'b0;
					end
				end
				RSC_USER:
				begin
					if (pin_slow_reg)
					begin
						state_next = RSC_USER_EXIT;
						hold_next = RSC_HOLD_CYCLES;
					end
				end
				RSC_USER_EXIT:
				begin
					if (!pin_slow_reg)
						state_next = RSC_USER;
					else if (hold_reg > 2'd1)
						hold_next = hold_reg - 2'd1;
					else
					begin
						state_next = RSC_IDLE;
						cause_next = pend_cause_reg;
						cpu_next = 1'b0;
						per_next = 1'b0;
					end
				end
				default:
				begin
					state_next = state_reg;
				end
			endcase
		end
	end

	// ==========================================================
	// pin pulse shaper
	always_comb
	begin
		pcnt_next = pcnt_reg;
		pin_drive_next = pin_drive_reg;
		pin_drive_d_next = pin_drive_reg;
		if (pin_start)
		begin
			pcnt_next = pulse_len(len);
			pin_drive_next = 1'b1;
		end
		else if (slow_clock_tick && pin_drive_reg)
		begin
			if (pcnt_reg <= PCNT_W'(1))
				pin_drive_next = 1'b0;
			pcnt_next = pcnt_reg - PCNT_W'(1);
		end
	end

	// ==========================================================
	// status, mode and apb
	always_comb
	begin
		pin_s_next = reset_pin_in;
		bod_d_next = brownout_detect;
		uflag_next = uflag_reg;
		bflag_next = bflag_reg;
		mode_next = mode_reg;
		resets_next.cpu_n = !cpu_next;
		resets_next.periph_n = !per_next;
		resets_next.pin_n = !pin_drive_next;
		if (status_read)
		begin
			uflag_next = 1'b0;
			bflag_next = 1'b0;
		end
		// set wins over the read clear
		if (pin_s_reg && !reset_pin_in)
			uflag_next = 1'b1;
		if (brownout_detect && !bod_d_reg && !brownout_reset_enable)
			bflag_next = 1'b1;
		if (wr && paddr == RSC_OFF_MODE && pwdata[RSC_KEY_LSB +: 8] == RSC_KEY)
		begin
			mode_next = 32'h0;
			mode_next[RSC_MD_UREN] = pwdata[RSC_MD_UREN];
			mode_next[RSC_MD_UIEN] = pwdata[RSC_MD_UIEN];
			mode_next[RSC_MD_BIEN] = pwdata[RSC_MD_BIEN];
			mode_next[RSC_MD_LEN_LSB +: LEN_BITS] =
				pwdata[RSC_MD_LEN_LSB +: LEN_BITS];
		end
		pready_next = acc ? 1'b1 : 1'b0;
		prdata_next = 32'h0;
		if (rd)
		begin
			case (paddr)
				RSC_OFF_STATUS:
				begin
					prdata_next[RSC_ST_USER] = uflag_reg;
					prdata_next[RSC_ST_BROWN] = bflag_reg;
					// read leaves cause alone
					prdata_next[RSC_ST_CAUSE_LSB +: 3] = cause_reg;
					prdata_next[RSC_ST_PIN] = pin_s_reg;
					prdata_next[RSC_ST_BUSY] = busy_reg;
				end
				RSC_OFF_MODE:
				begin
					prdata_next = mode_reg;
				end
				default:
				begin
					prdata_next = 32'h0;
				end
			endcase
		end
		irq_next = (uflag_next && mode_next[RSC_MD_UIEN]
			&& !mode_next[RSC_MD_UREN])
			|| (bflag_next && mode_next[RSC_MD_BIEN]);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= RSC_IDLE;
			hold_reg <= 2'd0;
			cause_reg <= RSC_CAUSE_POWER;
			pend_cause_reg <= RSC_CAUSE_POWER;
			cpu_reg <= 1'b0;
			per_reg <= 1'b0;
			busy_reg <= 1'b0;
			pcnt_reg <= '0;
			pin_drive_reg <= 1'b0;
			pin_s_reg <= 1'b1;
			pin_slow_reg <= 1'b1;
			uflag_reg <= 1'b0;
			bflag_reg <= 1'b0;
			bod_d_reg <= 1'b0;
			mode_reg <= RSC_MODE_RESET;
			prdata <= 32'h0;
			pready <= 1'b0;
			irq <= 1'b0;
			pin_drive_d_reg <= 1'b0;
			resets <= '1;
		end
		else
		begin
			state_reg <= state_next;
			hold_reg <= hold_next;
			cause_reg <= cause_next;
			pend_cause_reg <= pend_cause_next;
			cpu_reg <= cpu_next;
			per_reg <= per_next;
			busy_reg <= busy_next;
			pcnt_reg <= pcnt_next;
			pin_drive_reg <= pin_drive_next;
			pin_s_reg <= pin_s_next;
			pin_slow_reg <= pin_slow_next;
			uflag_reg <= uflag_next;
			bflag_reg <= bflag_next;
			bod_d_reg <= bod_d_next;
			mode_reg <= mode_next;
			prdata <= prdata_next;
			pready <= pready_next;
			irq <= irq_next;
			pin_drive_d_reg <= pin_drive_d_next;
			resets <= resets_next;
		end
	end

	assign pslverr = 1'b0;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = pin_drive_reg;
endmodule
`default_nettype wire

// ---- test/rsc_reset_controller_monitor.sv ----
// rsc_reset_controller_monitor: port assertions for the reset controller
// assumes it is bound to rsc_reset_controller
`timescale 1ns/1ps
`default_nettype none
module rsc_monitor
	import rsc_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// sources, pin and lines
	input wire logic power_fail,
	input wire logic brownout_detect,
	input wire logic brownout_reset_enable,
	input wire logic wdog_fault,
	input wire logic wdog_reset_enable,
	input wire logic wdog_cpu_only,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire rsc_pkg::rsc_resets_s resets
);
	// ==========================================
	// properties
	wire idle = resets.cpu_n & resets.periph_n & resets.pin_n & !reset_pin_oe
		& !power_fail & !(brownout_detect & brownout_reset_enable) & reset_pin_in;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence cmd_s;
		psel && penable && pwrite && !pready && paddr == RSC_OFF_COMMAND
			&& pwdata[31:24] == RSC_KEY && idle && !wdog_fault;
	endsequence
	sequence trip_s;
		wdog_fault && wdog_reset_enable;
	endsequence
	cmd_cpu_a: assert property (
		cmd_s ##0 pwdata[0] |-> ##[1:2] !resets.cpu_n) else $error("cpu line");
	cmd_per_a: assert property (
		cmd_s ##0 pwdata[2] |-> ##[1:2] !resets.periph_n) else $error("periph");
	cmd_pin_a: assert property (
		cmd_s ##0 pwdata[3] |-> ##[1:2] reset_pin_oe) else $error("pin drive");
	pin_low_a: assert property (
		reset_pin_oe |-> !reset_pin_out && !resets.pin_n) else $error("pin level");
	cmd_read_a: assert property (
		psel && penable && !pwrite && !pready && paddr == RSC_OFF_COMMAND
		|=> pready && prdata == 32'h0000_0000) else $error("command read");
	wdog_cpu_a: assert property (
		trip_s |-> ##[1:3] !resets.cpu_n) else $error("watchdog cpu");
	wdog_all_a: assert property (
		trip_s ##0 !wdog_cpu_only |-> ##[1:3] !resets.periph_n) else $error("wd");
	wdog_only_a: assert property (
		trip_s ##0 wdog_cpu_only && idle |=> resets.periph_n [*4])
		else $error("watchdog periph");
	pin_level_a: assert property (
		psel && penable && !pwrite && !pready && paddr == RSC_OFF_STATUS
		&& $stable(reset_pin_in) |=> prdata[RSC_ST_PIN] == $past(reset_pin_in))
		else $error("pin level bit");
endmodule
bind rsc_reset_controller rsc_monitor mon_u (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .power_fail,
	.brownout_detect, .brownout_reset_enable, .wdog_fault, .wdog_reset_enable,
	.wdog_cpu_only, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .resets);
`default_nettype wire

// ---- test/rsc_far_side.sv ----
// rsc_far_side: pulled-up reset pin, slow tick source, watchdog
// assumes pclk is the master clock
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side #(
	parameter int DIV = 16
)
(
	// clock
	input wire logic pclk,
	input wire logic presetn,
	// pin and watchdog
	input wire logic pin_oe,
	input wire logic pin_out,
	input wire logic ext_low,
	input wire logic cpu_n,
	input wire logic fault_req,
	output logic pin,
	output logic tick,
	output logic fault
);
	logic [7:0] cnt_reg;
	assign pin = (pin_oe ? pin_out : 1'b1) & !ext_low;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= 8'h00;
			tick <= 1'b0;
			fault <= 1'b0;
		end
		else
		begin
			cnt_reg <= (cnt_reg == 8'(DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
			tick <= (cnt_reg == 8'(DIV - 2));
			// a watchdog held in reset cannot trip
			fault <= fault_req & cpu_n;
		end
	end
endmodule
`default_nettype wire

// ---- test/rsc_reset_controller_bench.sv ----
// rsc_reset_controller_bench: self-checking bench for the reset controller
// assumes rsc_far_side for pin, slow tick and watchdog
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_controller_bench;
	import rsc_pkg::*;
	localparam int DIV = 16;
	localparam logic [31:0] KEY = {RSC_KEY, 24'h000000};
	localparam logic [31:0] WEXP [3] = '{32'h0, 32'h1, 32'h7};
	logic pclk, presetn, psel, penable, pwrite, pready, tick, irq, ext_low;
	logic power_fail, brownout_detect, brownout_reset_enable, fault_req;
	logic wdog_fault, wdog_reset_enable, wdog_cpu_only, pin, pin_out, pin_oe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, seed, m;
	logic [3:0] c;
	logic [2:0] lo, cause;
	rsc_resets_s resets;
	int n_mismatch, total_checks, ct, pt, i;
	rsc_reset_controller dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr(), .slow_clock_tick(tick),
		.power_fail, .brownout_detect, .brownout_reset_enable, .wdog_fault,
		.wdog_reset_enable, .wdog_cpu_only, .reset_pin_in(pin),
		.reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .resets, .irq);
	rsc_far_side #(.DIV(DIV)) far_u (.pclk, .presetn, .pin_oe, .pin_out,
		.ext_low, .cpu_n(resets.cpu_n), .fault_req, .pin, .tick,
		.fault(wdog_fault));
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ==========================================
	// lines seen low and slow ticks per episode
	always @(posedge pclk)
	begin
		lo = lo | ~{resets.pin_n, resets.periph_n, resets.cpu_n};
		ct = ct + int'(tick & !resets.cpu_n);
		pt = pt + int'(tick & pin_oe);
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic [31:0] lines(input logic [3:0] k);
		return {29'h0, k[3], k[2], k[0]};
	endfunction
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'(n < 20), 32'h1);
		if (n >= 20)
			conclude();
	endtask
	task sr(input logic [31:0] msk, input logic [31:0] e);
		bus(1'b0, RSC_OFF_STATUS, 32'h0);
		chk("status", r & msk, e);
	endtask
	task settle;
		int n;
		n = 0;
		repeat (4) @(posedge pclk);
		while (3'(resets) !== 3'b111 || pin_oe !== 1'b0)
		begin
			@(posedge pclk);
			n++;
			chk("settle", 32'(n < 4000), 32'h1);
			if (n >= 4000)
				conclude();
		end
		repeat (4 * DIV) @(posedge pclk);
	endtask
	task go;
		lo = 3'b000;
		ct = 0;
		pt = 0;
	endtask
	initial
	begin
		{psel, penable, pwrite, ext_low, fault_req, power_fail} = 6'h00;
		{brownout_detect, brownout_reset_enable} = 2'h0;
		{wdog_reset_enable, wdog_cpu_only} = 2'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		seed = 32'h6DFD;
		lo = 3'b000;
		cause = RSC_CAUSE_POWER;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		sr(32'hFFFF_FFFF, 32'h0001_0000);
		bus(1'b0, RSC_OFF_MODE, 32'h0);
		chk("mode", r, RSC_MODE_RESET);
		bus(1'b0, 8'h0C, 32'h0);
		chk("unmapped", r, 32'h0);
		bus(1'b0, RSC_OFF_COMMAND, 32'h0);
		chk("command read", r, 32'h0);
		for (i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			m = {20'h0, 2'h0, seed[1:0], 7'h00, seed[2]};
			bus(1'b1, RSC_OFF_MODE, KEY | m);
			bus(1'b0, RSC_OFF_MODE, 32'h0);
			chk("mode", {8'h00, r[23:0]}, m);
			c = {i[2], i[1], 1'b0, i[0]};
			go();
			bus(1'b1, RSC_OFF_COMMAND, (i == 0) ? 32'h5A00_000D : KEY | 32'(c));
			sr(32'h0002_0000, 32'(i != 0) << 17);
			if (i != 0)
				bus(1'b1, RSC_OFF_COMMAND, KEY | 32'h0000_000D);
			settle();
			chk("lines", 32'(lo), lines(c));
			if (c[0])
				cause = RSC_CAUSE_SW;
			if (c[0])
				chk("cpu ticks", 32'(ct), 32'h3);
			if (c[3])
				chk("pin ticks", 32'(pt), 32'h2 << m[9:8]);
			sr(32'h0000_0700, 32'(cause) << 8);
		end
		for (i = 0; i < 3; i++)
		begin
			wdog_reset_enable <= (i != 0);
			wdog_cpu_only <= (i == 1);
			go();
			if (i == 2)
				bus(1'b1, RSC_OFF_COMMAND, KEY | 32'h0000_0008);
			fault_req <= 1'b1;
			@(posedge pclk);
			fault_req <= 1'b0;
			settle();
			chk("wdog lines", 32'(lo), WEXP[i]);
			if (i != 0)
				cause = RSC_CAUSE_WDOG;
			if (i != 0)
				chk("wdog ticks", 32'(ct), 32'h3);
			sr(32'h0000_0700, 32'(cause) << 8);
		end
		bus(1'b1, RSC_OFF_MODE, KEY | 32'h0000_0010);
		sr(32'h0, 32'h0);
		go();
		ext_low <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("irq", 32'(irq), 32'h1);
		sr(32'h0001_0001, 32'h0000_0001);
		ext_low <= 1'b0;
		sr(32'h0001_0001, 32'h0001_0000);
		chk("irq", 32'(irq), 32'h0);
		chk("lines", 32'(lo), 32'h0);
		bus(1'b1, RSC_OFF_MODE, KEY | 32'h0000_0001);
		go();
		ext_low <= 1'b1;
		repeat (4 * DIV) @(posedge pclk);
		ext_low <= 1'b0;
		settle();
		chk("user", 32'(lo[0]), 32'h1);
		sr(32'h0000_0700, 32'(RSC_CAUSE_USER) << 8);
		bus(1'b1, RSC_OFF_MODE, KEY | 32'h0001_0000);
		brownout_detect <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("irq", 32'(irq), 32'h1);
		brownout_detect <= 1'b0;
		sr(32'h0000_0002, 32'h0000_0002);
		sr(32'h0000_0002, 32'h0);
		chk("irq", 32'(irq), 32'h0);
		brownout_reset_enable <= 1'b1;
		brownout_detect <= 1'b1;
		repeat (4) @(posedge pclk);
		brownout_detect <= 1'b0;
		settle();
		sr(32'h0000_0700, 32'(RSC_CAUSE_BROWN) << 8);
		{power_fail, fault_req} <= 2'h3;
		repeat (4) @(posedge pclk);
		{power_fail, fault_req} <= 2'h0;
		settle();
		sr(32'h0000_0700, 32'(RSC_CAUSE_POWER) << 8);
		conclude();
	end
endmodule
`default_nettype wire
